/* hdl/spi_port_defs.svh */
/*
 * Constants of the host serial port: register indices, field positions and
 * reset values. Assumes the includer compiles spi_port_pkg alongside it.
 */
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

// ============================================================
// register indices
`define OFS_OPCTL       7'h13
`define OFS_MASK        7'h18
`define OFS_STATUS      7'h19
`define OFS_FLAGS_CLEAR_ON_READ     7'h1A
`define OFS_READ_ONES_COUNT      7'h7E

// ============================================================
// fields and reset values
`define CMD_WRITE_BIT   7
`define OPCTL_SWRST_BIT 6
`define IRQ_RESET_BIT   16
`define MASK_RST        24'h000000
`define OPCTL_RST       8'h00

`endif

/* hdl/spi_port_pkg.sv */
/*
 * Types of the host serial port: serial engine states and the write byte
 * carried through the write buffer. Assumes no other package.
 */
package spi_port_pkg;

	// gray sequence idle -> command -> read; write differs from command in both bits
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CMD  = 2'b01,
		ST_RD   = 2'b11,
		ST_WR   = 2'b10
	} port_state_t;

	// one received write byte; lane 0 is the least significant byte
	typedef struct packed {
		logic [6:0] index;
		logic [1:0] lane;
		logic [7:0] data;
	} wr_byte_t;

endpackage : spi_port_pkg

/* hdl/byte_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, synchronous active-high reset, DEPTH a power of two.
 */
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;

	// ============================================================
	// flags: an extra pointer bit tells full from empty
	assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid = (wp_r != rp_r);
	assign out_data  = mem[rp_r[AW-1:0]];

	// storage
	always_ff @(posedge clk_sys) begin
		if (in_valid && in_ready) begin
			mem[wp_r[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wp_r <= wp_r + 1'b1;
			end
			if (out_valid && out_ready) begin
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule : byte_fifo
`default_nettype wire

/* hdl/serial_host_port.sv */
/*
 * Host-facing serial slave port: command decode, register read/write
 * shifting, read ones count, interrupt flags and mask, clear-on-read alias.
 * Assumes serial pins are asynchronous to clk_sys and the serial clock is
 * slower than one quarter of clk_sys; the metering datapath sits behind the
 * ext_* ports on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_defs.svh"
module serial_host_port
	import spi_port_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             dout,
	output logic             dout_oe,
	output logic             irq_n,
	input  wire logic [23:0] irq_event,
	output logic [6:0]       ext_rd_index,
	input  wire logic [23:0] ext_rd_data,
	input  wire logic [1:0]  ext_len,
	output logic             ext_wr_valid,
	input  wire logic        ext_wr_ready,
	output wr_byte_t         ext_wr,
	output logic             soft_rst
);
	// ============================================================
	// functions
	// byte count of a register; the datapath supplies widths it owns
	function automatic logic [1:0] reg_len(input logic [6:0] idx, input logic [1:0] ext);
		case (idx)
			`OFS_MASK, `OFS_STATUS, `OFS_FLAGS_CLEAR_ON_READ: reg_len = 2'd3;
			`OFS_READ_ONES_COUNT, `OFS_OPCTL: reg_len = 2'd1;
			default: reg_len = (ext == 2'd0) ? 2'd1 : ext;
		endcase
	endfunction : reg_len

	// registers held inside this port rather than in the datapath
	function automatic logic is_local(input logic [6:0] idx);
		is_local = (idx == `OFS_MASK) || (idx == `OFS_OPCTL) || (idx == `OFS_STATUS)
			|| (idx == `OFS_FLAGS_CLEAR_ON_READ) || (idx == `OFS_READ_ONES_COUNT);
	endfunction : is_local

	// ============================================================
	// declarations
	logic [2:0]  sclk_q;
	logic [2:0]  cs_q;
	logic [1:0]  din_q;
	port_state_t state_r;
	logic [7:0]  shift_r;
	logic [7:0]  shift_nxt;
	logic [2:0]  bit_cnt_r;
	logic [6:0]  index_r;
	logic        load_r;
	logic [1:0]  lane_r;
	logic [1:0]  len_w;
	logic [23:0] rd_word;
	logic [23:0] sh_r;
	logic [4:0]  bits_left_r;
	logic        dout_r;
	logic        dout_oe_r;
	logic [7:0]  chk_r;
	logic [23:0] status_r;
	logic [23:0] status_nxt;
	logic [23:0] mask_r;
	logic [7:0]  opctl_r;
	logic        soft_rst_r;
	logic        rst_pulse_r;
	logic        hold_r;
	logic [2:0]  hold_cnt_r;
	logic        irq_n_r;
	wr_byte_t    pend_r;
	logic        pend_valid_r;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	wr_byte_t    fifo_out;
	logic        drain_local;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_low;
	logic        cs_fall;
	logic        cs_rise;
	logic        byte_done;
	logic        rd_bit;
	logic        rclr;

	// ============================================================
	// pin synchronisers; stage 0 is read only by stage 1
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sclk_q <= 3'h7; // host parks the link clock high, so no false edge after reset
			cs_q   <= 3'h7;
			din_q  <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], sclk};
			cs_q   <= {cs_q[1:0], cs_n};
			din_q  <= {din_q[0], din};
		end
	end

	// edge detection on the synchronised levels
	assign sclk_rise = sclk_q[1] & ~sclk_q[2];
	assign sclk_fall = ~sclk_q[1] & sclk_q[2];
	assign cs_low    = ~cs_q[1];
	assign cs_fall   = ~cs_q[1] & cs_q[2];
	assign cs_rise   = cs_q[1] & ~cs_q[2];
	assign shift_nxt = {shift_r[6:0], din_q[1]};
	assign byte_done = sclk_fall && (bit_cnt_r == 3'd7)
		&& ((state_r == ST_CMD) || (state_r == ST_WR));
	assign rd_bit    = (state_r == ST_RD) && sclk_rise && (bits_left_r != 5'd0) && !load_r;
	assign rclr      = (state_r == ST_RD) && load_r && (index_r == `OFS_FLAGS_CLEAR_ON_READ);
	assign len_w     = reg_len(index_r, ext_len);

	// ============================================================
	// serial engine state
	// a raised select always wins, so a stuck host cannot wedge the port
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else if (!cs_low) begin
			state_r <= ST_IDLE;
		end else if (cs_fall || soft_rst_r) begin
			state_r <= ST_CMD;
		end else begin
			case (state_r)
				ST_IDLE: begin
					state_r <= ST_CMD;
				end
				ST_CMD: begin
					if (byte_done) begin
						state_r <= shift_nxt[`CMD_WRITE_BIT] ? ST_WR : ST_RD;
					end
				end
				ST_WR: begin
					if (byte_done && (lane_r == 2'd0)) begin
						state_r <= ST_CMD;
					end
				end
				ST_RD: begin
					if (sclk_fall && (bits_left_r == 5'd0) && !load_r) begin
						state_r <= ST_CMD;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// input shifter; a half byte left by an abort is simply restarted
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !cs_low || cs_fall || soft_rst_r) begin
			shift_r   <= 8'h00;
			bit_cnt_r <= 3'd0;
		end else if (sclk_fall && ((state_r == ST_CMD) || (state_r == ST_WR))) begin
			shift_r   <= shift_nxt;
			bit_cnt_r <= bit_cnt_r + 3'd1;
		end
	end

	// command capture, then one cycle to let the datapath present its word
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			index_r <= 7'h00;
			load_r  <= 1'b0;
		end else if ((state_r == ST_CMD) && byte_done && cs_low && !soft_rst_r) begin
			index_r <= shift_nxt[6:0];
			load_r  <= 1'b1;
		end else begin
			load_r  <= 1'b0;
		end
	end

	// ============================================================
	// write path: bytes go most significant first into the buffer
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lane_r <= 2'd0;
		end else if ((state_r == ST_WR) && load_r) begin
			lane_r <= len_w - 2'd1;
		end else if ((state_r == ST_WR) && byte_done) begin
			lane_r <= lane_r - 2'd1;
		end
	end

	// holding slot in front of the buffer; only whole bytes reach it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pend_r       <= '0;
			pend_valid_r <= 1'b0;
		end else if ((state_r == ST_WR) && byte_done && cs_low) begin
			pend_r.index <= index_r;
			pend_r.lane  <= lane_r;
			pend_r.data  <= shift_nxt;
			pend_valid_r <= 1'b1;
		end else if (fifo_in_ready) begin
			pend_valid_r <= 1'b0;
		end
	end

	byte_fifo #(
		.WIDTH ($bits(wr_byte_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.in_valid  (pend_valid_r),
		.in_ready  (fifo_in_ready),
		.in_data   (pend_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out)
	);

	// local registers drain at once; the rest wait on the datapath
	assign drain_local    = is_local(fifo_out.index);
	assign fifo_out_ready = drain_local | ext_wr_ready;
	assign ext_wr_valid   = fifo_out_valid & ~drain_local;
	assign ext_wr         = fifo_out;

	// mask and operating control; status and checksum ignore writes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mask_r     <= `MASK_RST;
			opctl_r    <= `OPCTL_RST;
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= 1'b0;
			if (soft_rst_r) begin
				mask_r <= `MASK_RST;
			end else if (fifo_out_valid && (fifo_out.index == `OFS_MASK)) begin
				mask_r[{fifo_out.lane, 3'b000} +: 8] <= fifo_out.data;
			end
			if (fifo_out_valid && (fifo_out.index == `OFS_OPCTL) && (fifo_out.lane == 2'd0)) begin
				opctl_r    <= fifo_out.data & ~(8'h01 << `OPCTL_SWRST_BIT);
				soft_rst_r <= fifo_out.data[`OPCTL_SWRST_BIT];
			end
		end
	end

	// ============================================================
	// read path: whole register captured at once, aligned to bit 23
	always_comb begin
		case (index_r)
			`OFS_MASK: rd_word = mask_r;
			`OFS_STATUS, `OFS_FLAGS_CLEAR_ON_READ: rd_word = status_r;
			`OFS_READ_ONES_COUNT: rd_word = {16'h0000, chk_r};
			`OFS_OPCTL: rd_word = {16'h0000, opctl_r};
			default: rd_word = ext_rd_data;
		endcase
	end

	// output shifter and pin drive
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !cs_low || soft_rst_r) begin
			sh_r        <= 24'h000000;
			bits_left_r <= 5'd0;
			dout_r      <= 1'b0;
			dout_oe_r   <= 1'b0;
		end else if ((state_r == ST_RD) && load_r) begin
			case (len_w)
				2'd1: sh_r <= {rd_word[7:0], 16'h0000};
				2'd2: sh_r <= {rd_word[15:0], 8'h00};
				default: sh_r <= rd_word;
			endcase
			bits_left_r <= {len_w, 3'b000};
		end else if (rd_bit) begin
			dout_r      <= sh_r[23];
			dout_oe_r   <= 1'b1;
			sh_r        <= {sh_r[22:0], 1'b0};
			bits_left_r <= bits_left_r - 5'd1;
		end else if ((state_r == ST_RD) && sclk_fall && (bits_left_r == 5'd0)) begin
			dout_oe_r   <= 1'b0;
		end
	end

	// ones count of the bits actually sent; snapshot precedes the clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			chk_r <= 8'h00;
		end else if ((state_r == ST_RD) && load_r) begin
			chk_r <= 8'h00;
		end else if (rd_bit) begin
			chk_r <= chk_r + {7'h00, sh_r[23]};
		end
	end

	// ============================================================
	// interrupt flags: a new event beats the read clear in the same cycle
	always_comb begin
		status_nxt = rclr ? 24'h000000 : status_r;
		status_nxt = status_nxt | irq_event;
		status_nxt[`IRQ_RESET_BIT] = rst_pulse_r;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			status_r    <= 24'h000000;
			rst_pulse_r <= 1'b1;
		end else begin
			status_r    <= status_nxt;
			rst_pulse_r <= soft_rst_r;
		end
	end

	// hold the interrupt high across a status read's first data byte
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hold_r     <= 1'b0;
			hold_cnt_r <= 3'd0;
		end else if ((state_r == ST_CMD) && byte_done && !shift_nxt[`CMD_WRITE_BIT]
			&& ((shift_nxt[6:0] == `OFS_STATUS) || (shift_nxt[6:0] == `OFS_FLAGS_CLEAR_ON_READ))) begin
			hold_r     <= 1'b1;
			hold_cnt_r <= 3'd0;
		end else if (hold_r && (!cs_low || (rd_bit && (hold_cnt_r == 3'd7)))) begin
			hold_r     <= 1'b0;
		end else if (hold_r && rd_bit) begin
			hold_cnt_r <= hold_cnt_r + 3'd1;
		end
	end

	// registered so the pin never glitches on mask or flag updates
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= ~(|(status_r & mask_r)) | hold_r;
		end
	end

	assign dout         = dout_r;
	assign dout_oe      = dout_oe_r;
	assign irq_n        = irq_n_r;
	assign soft_rst     = soft_rst_r;
	assign ext_rd_index = index_r;

	// ============================================================
	// assertions
	property p_chk_clear;
		@(posedge clk_sys) disable iff (sys_rst)
		((state_r == ST_RD) && load_r) |=> (chk_r == 8'h00) && !dout_oe_r;
	endproperty
	a_chk_clear: assert property (p_chk_clear) else $error("ones count not cleared at read start");

	property p_chk_count;
		@(posedge clk_sys) disable iff (sys_rst)
		rd_bit |=> (chk_r == $past(chk_r) + {7'h00, dout_r}) && dout_oe_r;
	endproperty
	a_chk_count: assert property (p_chk_count) else $error("ones count missed a sent bit");

	property p_flag_set;
		@(posedge clk_sys) disable iff (sys_rst)
		irq_event[0] |=> status_r[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event flag not set");

	property p_irq_low;
		@(posedge clk_sys) disable iff (sys_rst)
		(|(status_r & mask_r) && !hold_r) |=> !irq_n_r;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("masked pending flag did not pull irq low");

	property p_rclr;
		@(posedge clk_sys) disable iff (sys_rst)
		(rclr && !irq_event[1]) |=> !status_r[1];
	endproperty
	a_rclr: assert property (p_rclr) else $error("clear-on-read left a flag set");

	property p_keep_event;
		@(posedge clk_sys) disable iff (sys_rst)
		(rclr && irq_event[2]) |=> status_r[2];
	endproperty
	a_keep_event: assert property (p_keep_event) else $error("event lost during clear-on-read");

	property p_rst_flag;
		@(posedge clk_sys) disable iff (sys_rst)
		status_r[`IRQ_RESET_BIT] |=> !status_r[`IRQ_RESET_BIT];
	endproperty
	a_rst_flag: assert property (p_rst_flag) else $error("reset flag stayed high");

	property p_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		hold_r |=> irq_n_r;
	endproperty
	a_hold: assert property (p_hold) else $error("irq low during status read hold");

	property p_cs_fall;
		@(posedge clk_sys) disable iff (sys_rst)
		(cs_fall && !soft_rst_r) |=> (state_r == ST_CMD) && (bit_cnt_r == 3'd0);
	endproperty
	a_cs_fall: assert property (p_cs_fall) else $error("select fall did not enter command mode");

	property p_abort;
		@(posedge clk_sys) disable iff (sys_rst)
		cs_rise |=> !dout_oe_r && (state_r == ST_IDLE) ##1 !dout_oe_r;
	endproperty
	a_abort: assert property (p_abort) else $error("select rise did not abort");

	property p_release;
		@(posedge clk_sys) disable iff (sys_rst)
		((state_r == ST_RD) && sclk_fall && (bits_left_r == 5'd0) && !load_r && cs_low)
			|=> !dout_oe_r && (state_r == ST_CMD);
	endproperty
	a_release: assert property (p_release) else $error("output not released after last bit");
endmodule : serial_host_port
`default_nettype wire

/* tb/spi_host_model.sv */
/*
 * Behavioural host master for the serial port: frames transfers with cs_n,
 * drives sclk and din, samples dout. Assumes the port's clock runs at
 * least eight times the 320 ns link clock.
 */
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	// ============================================================
	// idle: deselected, link clock parked high
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end

	// one framed transfer; cut below the bit count aborts mid-frame
	task automatic xfer(input logic [7:0] cmd, input int nb, input logic [23:0] wd, input int cut,
		output logic [23:0] rd);
		int n;
		n    = 8 + 8 * nb;
		rd   = '0;
		cs_n = 1'b0;
		// din changes in the high phase so it is stable at every fall
		for (int i = 0; i < n && i < cut; i++) begin
			din = (i < 8) ? cmd[7 - i] : wd[n - 1 - i];
			#80 sclk = 1'b0;
			// sampled 240 ns after the rise that launched the bit
			#80 if (i >= 8) rd = {rd[22:0], dout_oe ? dout : 1'bx};
			#80 sclk = 1'b1;
			#80;
		end
		cs_n = 1'b1;
		din  = ~din; // released line: never hold the last value
		#1200;
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* tb/tb_serial_host_port.sv */
/*
 * Self-checking bench for serial_host_port: host model on the link, bench
 * stands in for the metering datapath. Assumes hdl/ on the include path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_defs.svh"
module tb_serial_host_port;
	import spi_port_pkg::*;

	// ============================================================
	// signals and model state
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        sclk, cs_n, din, dout, dout_oe, irq_n, ext_wr_valid, soft_rst;
	logic        ext_wr_ready = 1'b0;
	logic [23:0] irq_event    = '0;
	logic [23:0] ext_rd_data  = '0;
	logic [1:0]  ext_len      = 2'h1;
	logic [6:0]  ext_rd_index;
	wr_byte_t    ext_wr;
	wr_byte_t    wr_q[$];
	logic [23:0] v, v2, m, r, x, d, junk, status_m;
	int          n, cyc, soft_cnt, err_count, checks_done;

	spi_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

	serial_host_port #(.FIFO_DEPTH(16)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe(dout_oe), .irq_n(irq_n), .irq_event(irq_event),
		.ext_rd_index(ext_rd_index), .ext_rd_data(ext_rd_data), .ext_len(ext_len),
		.ext_wr_valid(ext_wr_valid), .ext_wr_ready(ext_wr_ready), .ext_wr(ext_wr),
		.soft_rst(soft_rst)
	);

	// ============================================================
	// clock, soft reset pulse counter and hang guard
	always #20 clk_sys = ~clk_sys;
	// counted on the falling edge so the registered pulse is settled when looked at
	always @(negedge clk_sys) begin
		cyc++;
		if (soft_rst === 1'b1) soft_cnt++;
		// whole run is about 5500 cycles; far beyond means a hang
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end

	// ============================================================
	// compares, bus helpers, reference ones count
	task automatic chk_reg(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_flag(input logic got, input logic exp);
		chk_reg({23'h0, got}, {23'h0, exp});
	endtask : chk_flag

	task automatic chk_wr(input wr_byte_t got, input wr_byte_t exp);
		chk_reg({7'h0, got}, {7'h0, exp});
	endtask : chk_wr

	task automatic rd_reg(input logic [6:0] idx, input int nb, output logic [23:0] val);
		host.xfer({1'b0, idx}, nb, 24'h000000, 99, val);
	endtask : rd_reg

	task automatic wr_reg(input logic [6:0] idx, input int nb, input logic [23:0] val);
		host.xfer({1'b1, idx}, nb, val, 99, junk);
	endtask : wr_reg

	// one-cycle event pulse, mirrored in the flag model
	task automatic ev(input logic [23:0] e);
		@(negedge clk_sys) irq_event = e;
		@(negedge clk_sys) irq_event = '0;
		status_m |= e;
	endtask : ev

	function automatic logic [23:0] ones(input logic [23:0] a);
		ones = '0;
		for (int i = 0; i < 24; i++) ones += 24'(a[i]);
	endfunction : ones

	task automatic stop_test();
		$display("mismatches %0d, comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// ============================================================
	// main sequence
	initial begin
		void'($urandom(32'h794C));
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (10) @(negedge clk_sys);
		status_m = '0;
		// reset flag must already be gone
		rd_reg(`OFS_STATUS, 3, v);
		chk_reg(v, status_m);
		// mask round trip: bit 0 enabled, bit 1 disabled
		m = ($urandom & 24'hFEFFFC) | 24'h000001;
		wr_reg(`OFS_MASK, 3, m);
		rd_reg(`OFS_MASK, 3, v);
		chk_reg(v, m);
		ev(24'h000002);
		repeat (4) @(negedge clk_sys);
		chk_flag(irq_n, 1'b1);
		rd_reg(`OFS_STATUS, 3, v);
		chk_reg(v, status_m);
		ev(24'h000001);
		repeat (4) @(negedge clk_sys);
		chk_flag(irq_n, 1'b0);
		r = $urandom & 24'hFEFFFF;
		ev(r);
		rd_reg(`OFS_FLAGS_CLEAR_ON_READ, 3, v);
		chk_reg(v, status_m);
		status_m = '0;
		chk_flag(irq_n, 1'b1);
		rd_reg(`OFS_READ_ONES_COUNT, 1, v2);
		chk_reg(v2, ones(v));
		rd_reg(`OFS_READ_ONES_COUNT, 1, v);
		chk_reg(v, ones(v2));
		rd_reg(`OFS_STATUS, 3, v);
		chk_reg(v, status_m);
		rd_reg(`OFS_READ_ONES_COUNT, 1, v);
		chk_reg(v, 24'h000000);
		// event lands mid clear-on-read: kept, interrupt held high meanwhile
		ev(24'h000001);
		fork
			rd_reg(`OFS_FLAGS_CLEAR_ON_READ, 3, v);
			begin
				// level events straddle the clearing edge, then a pulse lands mid-data
				#2400 irq_event = 24'h000005;
				#160 irq_event = '0;
				status_m = 24'h000005;
				#1280 ev(24'h000001);
				repeat (8) @(negedge clk_sys);
				chk_flag(irq_n, 1'b1);
			end
		join
		chk_reg(v, status_m);
		chk_flag(irq_n, 1'b0);
		// datapath stalls while 16 write bytes fill the buffer
		ext_len = 2'h2;
		for (int k = 0; k < 8; k++) begin
			d = $urandom & 24'h00FFFF;
			wr_reg(7'h20 + 7'(k), 2, d);
			wr_q.push_back({7'h20 + 7'(k), 2'h1, d[15:8]});
			wr_q.push_back({7'h20 + 7'(k), 2'h0, d[7:0]});
		end
		chk_flag(ext_wr_valid, 1'b1);
		n = 0;
		while (wr_q.size() > 0 && n < 2000) begin
			@(negedge clk_sys);
			ext_wr_ready = 1'($urandom);
			if (ext_wr_valid === 1'b1 && ext_wr_ready) chk_wr(ext_wr, wr_q.pop_front());
			n++;
		end
		chk_reg(24'(wr_q.size()), 24'h000000);
		@(negedge clk_sys) ext_wr_ready = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk_flag(ext_wr_valid, 1'b0);
		// datapath stalled again, so a leaked abort byte would stay visible
		ext_wr_ready = 1'b0;
		// aborted write byte and aborted read
		ext_len = 2'h1;
		host.xfer({1'b1, 7'h21}, 1, 24'h0000A5, 12, junk);
		repeat (6) @(negedge clk_sys);
		chk_flag(ext_wr_valid, 1'b0);
		host.xfer({1'b0, `OFS_MASK}, 3, 24'h000000, 13, junk);
		chk_flag(dout_oe, 1'b0);
		// whole word captured at the command despite a later change
		ext_len = 2'h3;
		x = $urandom & 24'hFFFFFF;
		ext_rd_data = x;
		fork
			rd_reg(7'h22, 3, v);
			#3000 @(negedge clk_sys) ext_rd_data = ~x;
		join
		chk_reg(v, x);
		chk_reg({17'h0, ext_rd_index}, 24'h000022);
		// software reset: one pulse, mask back to its reset value
		soft_cnt = 0;
		wr_reg(`OFS_OPCTL, 1, 24'h000040);
		chk_reg(24'(soft_cnt), 24'h000001);
		rd_reg(`OFS_MASK, 3, v);
		chk_reg(v, `MASK_RST);
		rd_reg(`OFS_OPCTL, 1, v);
		chk_reg(v, {16'h0000, `OPCTL_RST});
		stop_test();
	end
endmodule : tb_serial_host_port
`default_nettype wire
